// ---- design/bal_core.sv ----
`timescale 1ns/1ps
`include "bal_params.svh"

// Behaviour
// - add, add with carry; five flags, one cycle
// - subtract register or constant; five flags, one cycle
// - subtract with borrow, register or constant
// - pair plus constant; Z C N V S, two cycles
// - pair minus constant; Z C N V S, two cycles
// - AND with register or constant; Z N V
// - OR, OR constant, XOR; Z N V, one cycle
// - ones invert sets C; twos invert adds H
// - set bits by mask, Z N V only
// - clear bits by inverted mask, Z N V
// - three multiplies into R1:R0, Z C, two cycles
module bal_core import bal_pkg::*; #(
	parameter int PAIR_IMM_W = 6
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire bal_op_t op,
	input wire logic [7:0] opd_a,
	input wire logic [7:0] opd_hi,
	input wire logic [7:0] opd_b,
	input wire logic [7:0] imm,
	input wire logic carry_in,
	output logic busy_reg,
	output logic done_reg,
	output logic wr_lo_reg,
	output logic wr_hi_reg,
	output logic to_r1r0_reg,
	output logic [7:0] res_lo_reg,
	output logic [7:0] res_hi_reg,
	output logic [7:0] flags_reg,
	output logic [7:0] flag_upd_reg
);
	// the pair constant field cannot be wider than the byte path that adds it
	if (PAIR_IMM_W < 1 || PAIR_IMM_W > 8) begin : g_bad_imm_w
		$error("PAIR_IMM_W must lie in 1..8");
	end

	// status vector from result and arithmetic flags; S is always N^V
	function automatic logic [7:0] pack_flags(input logic [7:0] r, input logic z,
		input logic c, input logic v, input logic h);
		logic [7:0] f;
		f = `BAL_FLAGS_RST;
		f[`BAL_FLAG_C] = c;
		f[`BAL_FLAG_Z] = z;
		f[`BAL_FLAG_N] = r[7];
		f[`BAL_FLAG_V] = v;
		f[`BAL_FLAG_S] = r[7] ^ v;
		f[`BAL_FLAG_H] = h;
		return f;
	endfunction

	bal_state_t state_reg, state_next;
	logic pair_sub_reg, pair_c_reg, pair_z_reg;
	logic [7:0] pair_lo_reg, pair_hi_reg;
	logic [15:0] prod_reg;

	logic accept;
	assign accept = start && state_reg == ST_IDLE;

	// operation classes
	logic is_pair, is_mul, is_arith, is_sub, use_imm, use_cin, is_twos;
	assign is_pair = op == OP_PAIR_PLUS_IMM || op == OP_PAIR_MINUS_IMM;
	assign is_mul = op == OP_MUL || op == OP_MUL_SIGNED || op == OP_MIXED_SIGN_PRODUCT;
	assign is_twos = op == OP_TWOS_INVERT_PLUS_ONE;
	assign is_sub = op == OP_SUB || op == OP_MINUS_IMMEDIATE || op == OP_MINUS_REGS_BORROW
		|| op == OP_MINUS_IMM_BORROW || op == OP_PAIR_MINUS_IMM || is_twos;
	assign is_arith = is_sub || op == OP_ADD || op == OP_ADD_CARRY || is_pair;
	assign use_imm = op == OP_MINUS_IMMEDIATE || op == OP_MINUS_IMM_BORROW;
	assign use_cin = op == OP_ADD_CARRY || op == OP_MINUS_REGS_BORROW
		|| op == OP_MINUS_IMM_BORROW;

	// pair constant is limited to its field width
	logic [7:0] pair_k;
	assign pair_k = imm & 8'((9'h001 << PAIR_IMM_W) - 9'h001);

	// one shared adder: the low byte of every arithmetic operation, the high pair byte next cycle
	logic [7:0] add_a, add_b, add_sum;
	logic add_cin, add_sub, add_c, add_h, add_v;
	assign add_a = (state_reg == ST_PAIR_HI) ? pair_hi_reg : (is_twos ? 8'h00 : opd_a);
	assign add_b = (state_reg == ST_PAIR_HI) ? 8'h00
		: is_twos ? opd_a : is_pair ? pair_k : use_imm ? imm : opd_b;
	assign add_cin = (state_reg == ST_PAIR_HI) ? pair_c_reg : (use_cin & carry_in);
	assign add_sub = (state_reg == ST_PAIR_HI) ? pair_sub_reg : is_sub;

	bal_addsub8 u_addsub (
		.a(add_a),
		.b(add_b),
		.cin(add_cin),
		.sub(add_sub),
		.sum(add_sum),
		.cout(add_c),
		.hout(add_h),
		.vout(add_v)
	);

	// bitwise results; mask forms reuse the same gates with the constant
	logic [7:0] logic_res;
	assign logic_res = (op == OP_AND) ? (opd_a & opd_b)
		: (op == OP_CONJ_IMMEDIATE) ? (opd_a & imm)
		: (op == OP_OR) ? (opd_a | opd_b)
		: (op == OP_DISJ_IMMEDIATE) ? (opd_a | imm)
		: (op == OP_EXCLUSIVE_DISJ) ? (opd_a ^ opd_b)
		: (op == OP_SET_BITS_MASK) ? (opd_a | imm)
		: (op == OP_CLEAR_BITS_MASK) ? (opd_a & (`BAL_BYTE_ONES - imm))
		: (`BAL_BYTE_ONES - opd_a);

	// byte result, flags and update mask for single cycle operations
	logic [7:0] byte_res, byte_flags, byte_upd;
	assign byte_res = is_arith ? add_sum : logic_res;
	assign byte_flags = is_arith ? pack_flags(add_sum, add_sum == 8'h00, add_c, add_v, add_h)
		: pack_flags(logic_res, logic_res == 8'h00, op == OP_ONES_INVERT, 1'b0, 1'b0);
	assign byte_upd = is_arith ? `BAL_UPD_ARITH
		: (op == OP_ONES_INVERT) ? `BAL_UPD_ONES : `BAL_UPD_LOGIC;

	// product; operands widened to 9 bits so one signed multiplier serves all three
	logic [8:0] mul_a, mul_b;
	logic [17:0] mul_full;
	assign mul_a = {(op != OP_MUL) & opd_a[7], opd_a};
	assign mul_b = {(op == OP_MUL_SIGNED) & opd_b[7], opd_b};
	// operands sign-extended to the full width so the product is never cut short
	assign mul_full = $signed({{9{mul_a[8]}}, mul_a}) * $signed({{9{mul_b[8]}}, mul_b});

	// pair completion values: 16-bit zero from both halves, sign from high byte
	logic [7:0] pair_flags;
	assign pair_flags = pack_flags(add_sum, pair_z_reg && add_sum == 8'h00, add_c, add_v, 1'b0);

	// sequencing: byte ops finish at once, pair and multiply spend a second cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (accept && is_pair) begin
					state_next = ST_PAIR_HI;
				end else if (accept && is_mul) begin
					state_next = ST_MUL_OUT;
				end
			end
			ST_PAIR_HI: state_next = ST_IDLE;
			ST_MUL_OUT: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// hold the low half of a pair operation and the product between cycles
	always_ff @(posedge clk) begin
		if (accept) begin
			pair_sub_reg <= op == OP_PAIR_MINUS_IMM;
			pair_c_reg <= add_c;
			pair_z_reg <= add_sum == 8'h00;
			pair_lo_reg <= add_sum;
			pair_hi_reg <= opd_hi;
			prod_reg <= mul_full[15:0];
		end
	end

	// outputs; the write strobes and done are one cycle pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			wr_lo_reg <= 1'b0;
			wr_hi_reg <= 1'b0;
			to_r1r0_reg <= 1'b0;
			res_lo_reg <= 8'h00;
			res_hi_reg <= 8'h00;
			flags_reg <= `BAL_FLAGS_RST;
			flag_upd_reg <= 8'h00;
		end else begin
			busy_reg <= state_next != ST_IDLE;
			done_reg <= (accept && !is_pair && !is_mul) || state_reg != ST_IDLE;
			wr_lo_reg <= (accept && !is_pair && !is_mul) || state_reg != ST_IDLE;
			wr_hi_reg <= state_reg != ST_IDLE;
			to_r1r0_reg <= state_reg == ST_MUL_OUT;
			if (state_reg == ST_PAIR_HI) begin
				res_lo_reg <= pair_lo_reg;
				res_hi_reg <= add_sum;
				flags_reg <= pair_flags;
				flag_upd_reg <= `BAL_UPD_WORD;
			end else if (state_reg == ST_MUL_OUT) begin
				res_lo_reg <= prod_reg[7:0];
				res_hi_reg <= prod_reg[15:8];
				flags_reg <= pack_flags(8'h00, prod_reg == 16'h0000, prod_reg[15], 1'b0, 1'b0);
				flag_upd_reg <= `BAL_UPD_MUL;
			end else if (accept && !is_pair && !is_mul) begin
				res_lo_reg <= byte_res;
				res_hi_reg <= 8'h00;
				flags_reg <= byte_flags;
				flag_upd_reg <= byte_upd;
			end else begin
				flag_upd_reg <= 8'h00;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_pair_start;
		accept && is_pair;
	endsequence
	sequence s_two_cycle_end;
		!done_reg ##1 done_reg && wr_hi_reg;
	endsequence

	add_sum_a: assert property (accept && op == OP_ADD |=> done_reg && wr_lo_reg
		&& res_lo_reg == 8'($past(opd_a) + $past(opd_b)) && flag_upd_reg == 8'h2F)
		else $error("byte add result or timing wrong");
	minus_imm_a: assert property (accept && op == OP_MINUS_IMMEDIATE |=>
		res_lo_reg == 8'($past(opd_a) - $past(imm)) && flags_reg[0] == ($past(imm) > $past(opd_a)))
		else $error("subtract constant wrong");
	borrow_sub_a: assert property (accept && op == OP_MINUS_REGS_BORROW |=>
		res_lo_reg == 8'($past(opd_a) - $past(opd_b) - {7'h00, $past(carry_in)}))
		else $error("subtract with borrow wrong");
	pair_plus_a: assert property ((s_pair_start and op == OP_PAIR_PLUS_IMM) |=>
		s_two_cycle_end ##0 {res_hi_reg, res_lo_reg}
		== 16'({$past(opd_hi, 2), $past(opd_a, 2)} + {8'h00, $past(pair_k, 2)}))
		else $error("pair add wrong or not two cycles");
	pair_minus_a: assert property ((s_pair_start and op == OP_PAIR_MINUS_IMM) |=>
		s_two_cycle_end ##0 flag_upd_reg == 8'h1F && flags_reg[0] ==
		({$past(opd_hi, 2), $past(opd_a, 2)} < {8'h00, $past(pair_k, 2)}))
		else $error("pair subtract borrow wrong");
	logic_flags_a: assert property (accept && (op == OP_AND
		|| op == OP_EXCLUSIVE_DISJ) |=>
		flag_upd_reg == 8'h0E && !flags_reg[3] && flags_reg[1] == (res_lo_reg == 8'h00))
		else $error("logic flags wrong");
	ones_inv_a: assert property (accept && op == OP_ONES_INVERT |=>
		res_lo_reg == ~$past(opd_a) && flags_reg[0] && flag_upd_reg == 8'h0F)
		else $error("ones invert wrong");
	clear_mask_a: assert property (accept && op == OP_CLEAR_BITS_MASK |=>
		res_lo_reg == ($past(opd_a) & ~$past(imm)) && done_reg)
		else $error("clear bits by mask wrong");
	mul_two_a: assert property (accept && is_mul |=> !done_reg ##1
		done_reg && to_r1r0_reg && flags_reg[0] == res_hi_reg[7] && flag_upd_reg == 8'h03)
		else $error("multiply timing or carry wrong");
	sign_flag_a: assert property (done_reg && flag_upd_reg[4] |->
		flags_reg[2] == res_hi_reg[7] && flags_reg[4] == (res_hi_reg[7] ^ flags_reg[3]))
		else $error("sign flag not N xor V");
endmodule

// ---- design/bal_params.svh ----
`ifndef BAL_PARAMS_SVH
`define BAL_PARAMS_SVH

// status vector bit positions
`define BAL_FLAG_C 0
`define BAL_FLAG_Z 1
`define BAL_FLAG_N 2
`define BAL_FLAG_V 3
`define BAL_FLAG_S 4
`define BAL_FLAG_H 5

// which status bits each group of operations updates
`define BAL_UPD_ARITH 8'h2F
`define BAL_UPD_LOGIC 8'h0E
`define BAL_UPD_ONES 8'h0F
`define BAL_UPD_WORD 8'h1F
`define BAL_UPD_MUL 8'h03

// reset values and constants
`define BAL_FLAGS_RST 8'h00
`define BAL_BYTE_ONES 8'hFF

// cycles per operation, counted from the accepting edge
`define BAL_CYC_BYTE 1
`define BAL_CYC_WORD 2

`endif

// ---- design/bal_pkg.sv ----
package bal_pkg;

	// operations delivered by the instruction decoder
	typedef enum logic [4:0] {
		OP_ADD,
		OP_ADD_CARRY,
		OP_SUB,
		OP_MINUS_IMMEDIATE,
		OP_MINUS_REGS_BORROW,
		OP_MINUS_IMM_BORROW,
		OP_PAIR_PLUS_IMM,
		OP_PAIR_MINUS_IMM,
		OP_AND,
		OP_CONJ_IMMEDIATE,
		OP_OR,
		OP_DISJ_IMMEDIATE,
		OP_EXCLUSIVE_DISJ,
		OP_ONES_INVERT,
		OP_TWOS_INVERT_PLUS_ONE,
		OP_SET_BITS_MASK,
		OP_CLEAR_BITS_MASK,
		OP_MUL,
		OP_MUL_SIGNED,
		OP_MIXED_SIGN_PRODUCT
	} bal_op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PAIR_HI,
		ST_MUL_OUT
	} bal_state_t;

endpackage

// ---- design/bal_addsub8.sv ----
`timescale 1ns/1ps
// byte adder / subtractor with carry, half-carry and overflow
module bal_addsub8 (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	input wire logic sub,
	output logic [7:0] sum,
	output logic cout,
	output logic hout,
	output logic vout
);
	logic [8:0] full;
	logic [4:0] nib;

	// on subtraction the carry outputs mean borrow
	assign full = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
		: ({1'b0, a} + {1'b0, b} + {8'h00, cin});
	assign nib = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
		: ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
	assign sum = full[7:0];
	assign cout = full[8];
	assign hout = nib[4];
	// overflow: operand signs agree (add) or differ (sub) and result sign flips
	assign vout = sub ? ((a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]))
		: ((a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]));
endmodule

// ---- tb/bal_regfile_model.sv ----
`timescale 1ns/1ps
// register file stand-in: keeps whatever the datapath writes back
module bal_regfile_model (
	input wire logic clk,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic to_r1r0,
	input wire logic [7:0] res_lo,
	input wire logic [7:0] res_hi,
	output logic [15:0] dest_q,
	output logic [15:0] r1r0_q
);
	// products go to the fixed pair, so a wrong steer shows as a stale value
	always_ff @(posedge clk) begin
		if (wr_lo && !to_r1r0) dest_q[7:0] <= res_lo;
		if (wr_hi && !to_r1r0) dest_q[15:8] <= res_hi;
		if (wr_lo && wr_hi && to_r1r0) r1r0_q <= {res_hi, res_lo};
	end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench import bal_pkg::*;;
	logic clk, srst, start, carry_in, busy_reg, done_reg, wr_lo_reg, wr_hi_reg, to_r1r0_reg;
	bal_op_t op;
	logic [7:0] opd_a, opd_hi, opd_b, imm, res_lo_reg, res_hi_reg, flags_reg, flag_upd_reg;
	logic [15:0] dest_q, r1r0_q;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;

	bal_core #(.PAIR_IMM_W(6)) uut (.clk, .srst, .start, .op, .opd_a, .opd_hi, .opd_b, .imm,
		.carry_in, .busy_reg, .done_reg, .wr_lo_reg, .wr_hi_reg, .to_r1r0_reg, .res_lo_reg,
		.res_hi_reg, .flags_reg, .flag_upd_reg);
	bal_regfile_model rf (.clk, .wr_lo(wr_lo_reg), .wr_hi(wr_hi_reg), .to_r1r0(to_r1r0_reg),
		.res_lo(res_lo_reg), .res_hi(res_hi_reg), .dest_q, .r1r0_q);

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// flags and result of a byte add or subtract, worked out independently
	function automatic logic [15:0] ar(input logic [7:0] a, b, input logic c, s);
		logic [8:0] r;
		logic [4:0] t;
		logic v;
		r = s ? {1'b0, a} - b - c : {1'b0, a} + b + c;
		t = s ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
		v = (s ? a[7] != b[7] : a[7] == b[7]) && r[7] != a[7];
		return {2'b00, t[4], r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8], r[7:0]};
	endfunction

	// logic results clear overflow; carry is outside their mask
	function automatic logic [15:0] lf(input logic [7:0] r);
		return {4'h0, 1'b0, r[7], r == 8'h00, 1'b0, r};
	endfunction

	// one request; poke holds start through the busy cycle, which must be ignored
	task automatic run_op(input bal_op_t o, input logic [7:0] a, hi, b, k, input logic ci,
		input logic [15:0] er, input logic [7:0] ef, em, input int cyc, input logic poke);
		int n;
		@(posedge clk);
		op <= o;
		opd_a <= a;
		opd_hi <= hi;
		opd_b <= b;
		imm <= k;
		carry_in <= ci;
		start <= 1'b1;
		@(posedge clk);
		start <= poke;
		#1;
		n = 1;
		while (done_reg !== 1'b1 && n < 5) begin
			if (n == 1) chk("busy", 16'h0001, {15'h0000, busy_reg});
			@(posedge clk);
			start <= 1'b0;
			#1;
			n++;
		end
		chk("cycles", 16'(cyc), 16'(n));
		chk("flags", {8'h00, ef & em}, {8'h00, flags_reg & em});
		chk("flag mask", {8'h00, em}, {8'h00, flag_upd_reg});
		chk("writes", {14'h0000, cyc == 2, 1'b1}, {14'h0000, wr_hi_reg, wr_lo_reg});
		@(posedge clk);
		#1;
		chk("done pulse", 16'h0000, {15'h0000, done_reg});
		if (o >= OP_MUL) chk("product", er, r1r0_q);
		else chk("result", er, cyc == 2 ? dest_q : {8'h00, dest_q[7:0]});
	endtask

	task automatic byte_op(input bal_op_t o, input logic [7:0] a, b, k, input logic ci,
		input logic [15:0] x, input logic [7:0] em);
		run_op(o, a, 8'h00, b, k, ci, {8'h00, x[7:0]}, x[15:8], em, 1, 1'b0);
	endtask

	task automatic t_add;
		byte_op(OP_ADD, 8'h7F, 8'h01, 8'h00, 1'b1,
			ar(8'h7F, 8'h01, 1'b0, 1'b0), 8'h2F);
		byte_op(OP_ADD_CARRY, 8'hF8, 8'h08, 8'h00, 1'b1,
			ar(8'hF8, 8'h08, 1'b1, 1'b0), 8'h2F);
		$display("test add done");
	endtask

	task automatic t_sub;
		byte_op(OP_SUB, 8'h80, 8'h01, 8'hAA, 1'b1,
			ar(8'h80, 8'h01, 1'b0, 1'b1), 8'h2F);
		byte_op(OP_MINUS_IMMEDIATE, 8'h10, 8'hAA, 8'h20, 1'b0,
			ar(8'h10, 8'h20, 1'b0, 1'b1), 8'h2F);
		byte_op(OP_MINUS_REGS_BORROW, 8'h00, 8'h00, 8'h55, 1'b1,
			ar(8'h00, 8'h00, 1'b1, 1'b1), 8'h2F);
		byte_op(OP_MINUS_IMM_BORROW, 8'h05, 8'h55, 8'h05, 1'b0,
			ar(8'h05, 8'h05, 1'b0, 1'b1), 8'h2F);
		$display("test subtract done");
	endtask

	task automatic t_pair;
		run_op(OP_PAIR_PLUS_IMM, 8'hFF, 8'h7F, 8'h00, 8'h3F, 1'b0,
			16'h803E, 8'h0C, 8'h1F, 2, 1'b1);
		run_op(OP_PAIR_MINUS_IMM, 8'h00, 8'h00, 8'h00, 8'hC1, 1'b0,
			16'hFFFF, 8'h15, 8'h1F, 2, 1'b1);
		$display("test pair done");
	endtask

	// one table walks every logic and mask operation
	task automatic t_logic;
		bal_op_t ops[7] = '{OP_AND, OP_CONJ_IMMEDIATE, OP_OR, OP_DISJ_IMMEDIATE,
			OP_EXCLUSIVE_DISJ, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK};
		logic [7:0] res[7] = '{8'h42, 8'h00, 8'hDB, 8'hFF, 8'h99, 8'hFF, 8'hC3};
		for (int i = 0; i < 7; i++) begin
			byte_op(ops[i], 8'hC3, 8'h5A, 8'h3C, 1'b1,
				lf(res[i]), 8'h0E);
		end
		$display("test logic done");
	endtask

	task automatic t_invert;
		byte_op(OP_ONES_INVERT, 8'hFF, 8'h00, 8'h00, 1'b0, 16'h0300, 8'h0F);
		byte_op(OP_TWOS_INVERT_PLUS_ONE, 8'h80, 8'h00, 8'h00, 1'b0,
			ar(8'h00, 8'h80, 1'b0, 1'b1), 8'h2F);
		$display("test invert done");
	endtask

	task automatic t_mul;
		run_op(OP_MUL, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'b0,
			16'hFE01, 8'h01, 8'h03, 2, 1'b0);
		run_op(OP_MUL, 8'h00, 8'h00, 8'h37, 8'h00, 1'b1,
			16'h0000, 8'h02, 8'h03, 2, 1'b0);
		run_op(OP_MUL_SIGNED, 8'h80, 8'h00, 8'h02, 8'h00, 1'b0,
			16'hFF00, 8'h01, 8'h03, 2, 1'b0);
		run_op(OP_MIXED_SIGN_PRODUCT, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'b0,
			16'hFF01, 8'h01, 8'h03, 2, 1'b0);
		$display("test multiply done");
	endtask

	// reset in the busy cycle of a pair op must drop it with no write or done
	task automatic t_reset;
		@(posedge clk);
		op <= OP_PAIR_PLUS_IMM;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		#1;
		chk("reset idle", 16'h0000, {4'h0, done_reg, busy_reg, wr_lo_reg, wr_hi_reg, flag_upd_reg});
		byte_op(OP_ADD, 8'h01, 8'h02, 8'h00, 1'b0,
			ar(8'h01, 8'h02, 1'b0, 1'b0), 8'h2F);
		$display("test reset done");
	endtask

	// 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// hang guard: the whole run needs about 80 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			close_out;
		end
	end

	initial begin
		srst = 1'b1;
		start = 1'b0;
		op = OP_ADD;
		{opd_a, opd_hi, opd_b, imm, carry_in} = '0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk("idle", 16'h0000, {6'h00, done_reg, busy_reg, flag_upd_reg});
		t_add;
		t_sub;
		t_pair;
		t_logic;
		t_invert;
		t_mul;
		t_reset;
		close_out;
	end
endmodule
